// *** ahfs_pkg.sv ***
// Shared constants and types for the ADC host frame-sync block
package ahfs_pkg;

  // ------------------------------------------------------------
  // Frame geometry
  // ------------------------------------------------------------
  localparam int CHANNELS    = 4;
  localparam int WORD_BITS   = 24;
  localparam int FRAME_WORDS = CHANNELS + 2;
  localparam int FRAME_BITS  = WORD_BITS * FRAME_WORDS;
  localparam int CRC_BITS    = 16;

  // ------------------------------------------------------------
  // Timing defaults in system clock cycles, and result FIFO depth in entries
  // ------------------------------------------------------------
  localparam int CONV_PERIOD_CYCLES = 2048;
  localparam int READY_GAP_CYCLES   = 4;
  localparam int FIFO_DEPTH         = 2;

  // ------------------------------------------------------------
  // Status word layout and CRC
  // ------------------------------------------------------------
  localparam int STAT_REALIGN_BIT = 23;
  localparam int STAT_LEVEL_LSB   = 0;
  localparam logic [CRC_BITS-1:0] CRC_INIT = 16'hFFFF;
  localparam logic [CRC_BITS-1:0] CRC_POLY = 16'h1021;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef logic [WORD_BITS-1:0] ahfs_word_t;

  typedef struct packed {
    ahfs_word_t [CHANNELS-1:0] ch;
  } ahfs_sample_t;

  typedef struct packed {
    ahfs_word_t   status;
    ahfs_sample_t data;
    ahfs_word_t   crc;
  } ahfs_frame_t;

  typedef enum logic [1:0] {
    DR_EMPTY,
    DR_GAP,
    DR_READY
  } ahfs_ready_state_t;

endpackage

// *** ahfs_fifo_mem.sv ***
// Small conversion result memory with registered read data
`timescale 1ns/100ps
module ahfs_fifo_mem #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 2,
  parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Write port
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read port
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// *** ahfs_top.sv ***
// ADC host-side frame sync: result FIFO, data-ready, sync check and serial frame output
`timescale 1ns/100ps
module ahfs_top #(
  parameter int CONV_PERIOD = ahfs_pkg::CONV_PERIOD_CYCLES,
  parameter int READY_GAP   = ahfs_pkg::READY_GAP_CYCLES
) (
  // System clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  // Converter core
  input  wire ahfs_pkg::ahfs_sample_t sample_i,
  // Host pins
  input  wire logic                  sclk_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  sync_reset_n_i,
  output logic                       dout_o,
  output logic                       dout_oe_o,
  output logic                       data_ready_n_o,
  // Status
  output logic                       realign_flag_o
);

  // ------------------------------------------------------------
  // Local widths
  // ------------------------------------------------------------
  localparam int AW    = (ahfs_pkg::FIFO_DEPTH > 1) ? $clog2(ahfs_pkg::FIFO_DEPTH) : 1;
  localparam int LW    = $clog2(ahfs_pkg::FIFO_DEPTH + 1);
  localparam int CW    = $clog2(CONV_PERIOD);
  localparam int GW    = $clog2(READY_GAP + 1);
  localparam int BW    = $clog2(ahfs_pkg::FRAME_BITS + 1);
  localparam int SW    = $bits(ahfs_pkg::ahfs_sample_t);
  localparam int CRC_IN = ahfs_pkg::WORD_BITS * (ahfs_pkg::CHANNELS + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_PERIOD - 1);
  localparam logic [GW-1:0] GAP_LOAD  = GW'(READY_GAP);
  localparam logic [LW-1:0] LVL_FULL  = LW'(ahfs_pkg::FIFO_DEPTH);
  localparam logic [LW-1:0] LVL_ONE   = LW'(1);
  localparam logic [BW-1:0] BIT_END   = BW'(ahfs_pkg::FRAME_BITS);
  localparam logic [BW-1:0] BIT_LAST  = BW'(ahfs_pkg::FRAME_BITS - 1);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    logic [AW-1:0] r;
    r = (p == AW'(ahfs_pkg::FIFO_DEPTH - 1)) ? '0 : AW'(p + AW'(1));
    return r;
  endfunction

  function automatic logic [ahfs_pkg::CRC_BITS-1:0] frame_crc(input logic [CRC_IN-1:0] d);
    logic [ahfs_pkg::CRC_BITS-1:0] c;
    logic                          fb;
    c  = ahfs_pkg::CRC_INIT;
    fb = 1'b0;
    for (int i = CRC_IN - 1; i >= 0; i--) begin
      fb = c[ahfs_pkg::CRC_BITS-1] ^ d[i];
      c  = {c[ahfs_pkg::CRC_BITS-2:0], 1'b0};
      if (fb) begin
        c = c ^ ahfs_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // Pin and frame-done toggle synchronisers
  // ------------------------------------------------------------
  logic sync_meta, sync_q, sync_q_d;
  logic cs_meta, cs_q;
  logic done_meta, done_q, done_q_d;
  logic done_tgl;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_meta <= 1'b1;
      sync_q    <= 1'b1;
      sync_q_d  <= 1'b1;
      cs_meta   <= 1'b1;
      cs_q      <= 1'b1;
      done_meta <= 1'b0;
      done_q    <= 1'b0;
      done_q_d  <= 1'b0;
    end else begin
      sync_meta <= sync_reset_n_i;
      sync_q    <= sync_meta;
      sync_q_d  <= sync_q;
      cs_meta   <= cs_n_i;
      cs_q      <= cs_meta;
      done_meta <= done_tgl;
      done_q    <= done_meta;
      done_q_d  <= done_q;
    end
  end

  wire sync_fall  = sync_q_d & ~sync_q;
  wire frame_done = done_q ^ done_q_d;

  // ------------------------------------------------------------
  // Conversion period and sync check
  // ------------------------------------------------------------
  logic [CW-1:0] conv_cnt;
  logic          realign_flag;

  wire conv_tick  = (conv_cnt == CONV_LAST) & ~sync_fall;
  wire misaligned = sync_fall & (conv_cnt != '0);
  wire next_realign = misaligned | (realign_flag & ~frame_done);
  wire [CW-1:0] next_conv_cnt = (sync_fall | conv_tick) ? '0 : CW'(conv_cnt + CW'(1));

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_cnt     <= '0;
      realign_flag <= 1'b0;
    end else begin
      conv_cnt     <= next_conv_cnt;
      realign_flag <= next_realign;
    end
  end

  assign realign_flag_o = realign_flag;

  // ------------------------------------------------------------
  // Result FIFO
  // ------------------------------------------------------------
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [LW-1:0] level;
  logic [SW-1:0] head_data;

  wire fifo_full  = (level == LVL_FULL);
  wire fifo_empty = (level == '0);
  wire pop        = frame_done & ~fifo_empty;
  // overflow keeps only the newest result
  wire overflow   = conv_tick & fifo_full & ~pop;

  wire [LW-1:0] next_level = overflow ? LVL_ONE
                           : LW'(level + LW'(conv_tick) - LW'(pop));
  wire [AW-1:0] next_rd_ptr = overflow ? wr_ptr : (pop ? ptr_inc(rd_ptr) : rd_ptr);
  wire [AW-1:0] next_wr_ptr = conv_tick ? ptr_inc(wr_ptr) : wr_ptr;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end

  ahfs_fifo_mem #(
    .WIDTH (SW),
    .DEPTH (ahfs_pkg::FIFO_DEPTH)
  ) u_mem (
    .clk_i     (sys_clk_i),
    .reset_i   (reset_i),
    .wr_en_i   (conv_tick),
    .wr_addr_i (wr_ptr),
    .wr_data_i (sample_i),
    .rd_addr_i (next_rd_ptr),
    .rd_data_o (head_data)
  );

  // ------------------------------------------------------------
  // Data-ready sequencing
  // ------------------------------------------------------------
  ahfs_pkg::ahfs_ready_state_t state, next_state;
  logic [GW-1:0] gap_cnt, next_gap_cnt;
  logic          ready_n;

  // The gap also covers the one-cycle read latency of the memory
  always_comb begin
    next_state   = state;
    next_gap_cnt = gap_cnt;
    case (state)
      ahfs_pkg::DR_EMPTY: begin
        if (conv_tick) begin
          next_state   = ahfs_pkg::DR_GAP;
          next_gap_cnt = GAP_LOAD;
        end
      end
      // high again once the frame is read
      ahfs_pkg::DR_READY: begin
        if (overflow || pop) begin
          next_state   = (next_level == '0) ? ahfs_pkg::DR_EMPTY : ahfs_pkg::DR_GAP;
          next_gap_cnt = GAP_LOAD;
        end
      end
      ahfs_pkg::DR_GAP: begin
        if (overflow) begin
          next_gap_cnt = GAP_LOAD;
        end else if (gap_cnt != '0) begin
          next_gap_cnt = GW'(gap_cnt - GW'(1));
        end else begin
          next_state = (level == '0) ? ahfs_pkg::DR_EMPTY : ahfs_pkg::DR_READY;
        end
      end
      default: begin
        next_state   = ahfs_pkg::DR_EMPTY;
        next_gap_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state   <= ahfs_pkg::DR_EMPTY;
      gap_cnt <= '0;
      ready_n <= 1'b1;
    end else begin
      state   <= next_state;
      gap_cnt <= next_gap_cnt;
      // low while a new frame waits
      ready_n <= (next_state != ahfs_pkg::DR_READY);
    end
  end

  assign data_ready_n_o = ready_n;

  // ------------------------------------------------------------
  // Frame assembly, frozen while chip select is low
  // ------------------------------------------------------------
  ahfs_pkg::ahfs_word_t  status_word;
  ahfs_pkg::ahfs_frame_t frame_now, frame_hold;

  always_comb begin
    status_word = '0;
    status_word[ahfs_pkg::STAT_REALIGN_BIT] = realign_flag;
    status_word[ahfs_pkg::STAT_LEVEL_LSB +: LW] = level;
    frame_now.status = status_word;
    frame_now.data   = head_data;
    frame_now.crc    = ahfs_pkg::WORD_BITS'(frame_crc({status_word, head_data}));
  end

  // Holding the frame steady makes it quasi-static for the link domain
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      frame_hold <= '0;
    end else if (cs_q) begin
      frame_hold <= frame_now;
    end
  end

  // ------------------------------------------------------------
  // Link domain: serial shifter on the host clock
  // ------------------------------------------------------------
  logic [BW-1:0]                  bit_cnt;
  logic [ahfs_pkg::FRAME_BITS-1:0] shreg;
  logic                           dout;

  // Chip select high ends the frame even though the clock has stopped
  wire link_rst = reset_i | cs_n_i;

  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= '0;
      shreg   <= '0;
      dout    <= 1'b0;
    end else if (bit_cnt == '0) begin
      shreg   <= {frame_hold[ahfs_pkg::FRAME_BITS-2:0], 1'b0};
      dout    <= frame_hold[ahfs_pkg::FRAME_BITS-1];
      bit_cnt <= BW'(1);
    end else if (bit_cnt != BIT_END) begin
      shreg   <= {shreg[ahfs_pkg::FRAME_BITS-2:0], 1'b0};
      dout    <= shreg[ahfs_pkg::FRAME_BITS-1];
      bit_cnt <= BW'(bit_cnt + BW'(1));
    end else begin
      dout    <= 1'b0;
    end
  end

  // full frame shifted marks data read
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      done_tgl <= 1'b0;
    end else if (!cs_n_i && bit_cnt == BIT_LAST) begin
      done_tgl <= ~done_tgl;
    end
  end

  assign dout_o    = dout;
  assign dout_oe_o = ~cs_n_i;

endmodule

// *** ahfs_top_properties.sv ***
// Port-level assertions for the ADC host frame-sync block
`timescale 1ns/100ps
module ahfs_top_properties #(
  parameter int CONV_PERIOD = 2048,
  parameter int READY_GAP   = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Host pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sync_reset_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic data_ready_n_o,
  input wire logic realign_flag_o
);
  logic [7:0] bit_cnt;
  logic       done_tgl;
  logic [2:0] done_sync;
  wire        done_seen = done_sync[2] ^ done_sync[1];
  // Toggle per whole frame, crossed by flops since the link clock stops
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) bit_cnt <= 8'h00;
    else if (bit_cnt != 8'hFF) bit_cnt <= bit_cnt + 8'h01;
  end
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) done_tgl <= 1'b0;
    else if (!cs_n_i && bit_cnt == 8'h8F) done_tgl <= ~done_tgl;
  end
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) done_sync <= 3'h0;
    else done_sync <= {done_sync[1:0], done_tgl};
  end
  // High for the gap count plus the cycle the gap counter spends at zero
  sequence s_gap_high;
    data_ready_n_o [*5];
  endsequence
  sequence s_freed;
    ##[1:10] data_ready_n_o;
  endsequence
  a_oe_follows_cs: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    dout_oe_o == !cs_n_i) else $error("enable differs from select");
  a_dout_released: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cs_n_i |-> !dout_o) else $error("data while deselected");
  a_ready_gap_high: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(data_ready_n_o) |-> s_gap_high) else $error("ready gap short");
  a_read_frees_ready: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    done_seen && !data_ready_n_o |-> s_freed) else $error("ready held after frame");
  a_flag_needs_sync: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(realign_flag_o) |-> !$past(sync_reset_n_i, 3)) else $error("flag without sync");
  a_flag_clear_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(realign_flag_o) |-> !$past(cs_n_i, 4)) else $error("flag cleared idle");
  a_sync_no_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !sync_reset_n_i && cs_n_i && !data_ready_n_o |=> !data_ready_n_o) else $error("sync lost data");
  a_tail_bits_zero: assert property (@(posedge sclk_i) disable iff (reset_i)
    bit_cnt > 8'h90 |-> !dout_o) else $error("data past frame end");
endmodule
bind ahfs_top ahfs_top_properties #(.CONV_PERIOD(CONV_PERIOD), .READY_GAP(READY_GAP)) chk_u (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .sync_reset_n_i(sync_reset_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .data_ready_n_o(data_ready_n_o), .realign_flag_o(realign_flag_o));

// *** ahfs_host_model.sv ***
// Host controller model reading whole or partial frames
`timescale 1ns/100ps
module ahfs_host_model (
  // Serial link
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o
);
  // Link clock stands low between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end
  task automatic xfer(input int nbits, output logic [143:0] frm);
    frm = 144'h0;
    #2;
    cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      sclk_o = 1'b1;
      #40;
      sclk_o = 1'b0;
      if (i < 144) frm = {frm[142:0], miso_i};
      #40;
    end
    #100;
    cs_n_o = 1'b1;
    #60;
  endtask
endmodule

// *** ahfs_testbench.sv ***
// Self-checking bench for the ADC host frame-sync block
`timescale 1ns/100ps
module testbench;
  localparam int CP = 1600;
  logic                   sys_clk;
  logic                   reset;
  logic                   sync_n;
  ahfs_pkg::ahfs_sample_t sample;
  wire logic              sclk;
  wire logic              cs_n;
  wire logic              miso;
  logic                   dout;
  logic                   dout_oe;
  logic                   ready_n;
  logic                   flag;
  logic [143:0]           frm;
  int                     fails;
  int                     n_compared;
  // Released line shows the inverse, so a stale bit cannot pass
  assign miso = dout_oe ? dout : ~dout;
  ahfs_top #(.CONV_PERIOD(CP)) dut_u (
    .sys_clk_i(sys_clk), .reset_i(reset), .sample_i(sample), .sclk_i(sclk), .cs_n_i(cs_n),
    .sync_reset_n_i(sync_n), .dout_o(dout), .dout_oe_o(dout_oe), .data_ready_n_o(ready_n),
    .realign_flag_o(flag));
  ahfs_host_model host_u (.miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // CRC-16 reference, seeded and fed MSB first as the frame defines it
  function automatic logic [23:0] ref_crc(input logic [119:0] d);
    logic [15:0] c;
    c = ahfs_pkg::CRC_INIT;
    for (int i = 119; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ ahfs_pkg::CRC_POLY) : {c[14:0], 1'b0};
    end
    return {8'h00, c};
  endfunction
  task automatic stop_test();
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk({94'h0, ready_n, flag}, 96'h2, "reset outputs");
  endtask
  task automatic wait_low(input int lim);
    int k;
    k = 0;
    while (ready_n !== 1'b0 && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    chk({95'h0, k < lim}, 96'h1, "ready timeout");
  endtask
  // one common sync pulse for the group
  task automatic pulse_sync();
    sync_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    sync_n <= 1'b1;
  endtask
  task automatic t_full();
    sample <= 96'h0123_4567_89AB_CDEF_1357_9BDF;
    wait_low(2 * CP);
    host_u.xfer(146, frm);
    chk(frm[119:24], 96'h0123_4567_89AB_CDEF_1357_9BDF, "first data");
    chk({72'h0, frm[143:120]}, 96'h1, "first status");
    chk({72'h0, frm[23:0]}, {72'h0, ref_crc({24'h00_0001, 96'h0123_4567_89AB_CDEF_1357_9BDF})}, "check word");
    // Channel 0 serves as the zero-phase reference of the group
    chk({72'h0, frm[47:24]}, 96'h57_9BDF, "reference channel");
    chk({95'h0, ready_n}, 96'h1, "ready after read");
  endtask
  task automatic t_partial();
    logic [95:0] b;
    b = 96'hFEDC_BA98_7654_3210_0F1E_2D3C;
    @(posedge sys_clk);
    sample <= b;
    wait_low(2 * CP);
    host_u.xfer(48, frm);
    chk({72'h0, frm[23:0]}, {72'h0, b[95:72]}, "partial word");
    @(posedge sys_clk);
    sample <= ~b;
    host_u.xfer(144, frm);
    chk(frm[119:24], b, "repeat after partial");
    wait_low(CP);
    host_u.xfer(144, frm);
    chk(frm[119:24], ~b, "second entry");
  endtask
  // Unread results, falls counted over seven and a half periods
  task automatic t_overflow();
    int   falls;
    logic prev;
    falls = 0;
    prev  = 1'b0;
    do_reset();
    wait_low(2 * CP);
    repeat (CP * 15 / 2) begin
      @(posedge sys_clk);
      if (prev === 1'b1 && ready_n === 1'b0) falls++;
      prev = ready_n;
    end
    chk(96'(falls), 96'h3, "falls while unread");
  endtask
  task automatic t_sync();
    do_reset();
    repeat (400) @(posedge sys_clk);
    pulse_sync();
    repeat (CP - 388) @(posedge sys_clk);
    chk({94'h0, flag, ready_n}, 96'h3, "stray sync");
    wait_low(CP);
    host_u.xfer(144, frm);
    chk({72'h0, frm[143:120]}, 96'h80_0001, "status flag");
    chk({95'h0, flag}, 96'h0, "flag clear");
    wait_low(2 * CP);
    // Pulse seen just as the next period starts, so it is in step
    repeat (CP - 8) @(posedge sys_clk);
    pulse_sync();
    repeat (8) @(posedge sys_clk);
    chk({94'h0, flag, ready_n}, 96'h0, "aligned sync");
    pulse_sync();
    repeat (8) @(posedge sys_clk);
    chk({94'h0, flag, ready_n}, 96'h2, "sync again");
  endtask
  initial begin
    reset      = 1'b1;
    sync_n     = 1'b1;
    sample     = 96'h0;
    fails      = 0;
    n_compared = 0;
    do_reset();
    t_full();
    t_partial();
    t_overflow();
    t_sync();
    stop_test();
  end
  // About two and a half times the expected run
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test();
  end
endmodule
